// ---- verilog/nvm_cfg_pkg.sv ----
package nvm_cfg_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS   = 100;
	localparam int unsigned WIPE_MIN_MS     = 220;
	// A least time: round up to whole cycles
	localparam int unsigned WIPE_CYCLES_DEF =
		(WIPE_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WIPE_CNT_W      = 22;

	// ------------------------------------------------------------
	// Register port map
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned DATA_W     = 32;
	localparam logic [7:0]  ADDR_CMD   = 8'h00;
	localparam logic [7:0]  ADDR_STAT  = 8'h04;
	localparam logic [7:0]  ADDR_CALIB = 8'h08;

	// Command word fields
	localparam int unsigned CMD_LSB    = 0;
	localparam int unsigned CMD_MSB    = 3;
	localparam int unsigned IDX_LSB    = 8;
	localparam int unsigned IDX_MSB    = 9;

	// Status word fields
	localparam int unsigned ST_GP_LSB  = 0;
	localparam int unsigned ST_GP_MSB  = 2;
	localparam int unsigned ST_SEC     = 4;
	localparam int unsigned ST_ARMED   = 5;
	localparam int unsigned ST_FFP     = 6;
	localparam int unsigned ST_WIPE    = 7;

	// ------------------------------------------------------------
	// General bits
	// ------------------------------------------------------------
	localparam int unsigned GP_N       = 3;
	localparam int unsigned GP_BOD_EN  = 0;
	localparam int unsigned GP_BOD_RST = 1;
	localparam int unsigned GP_BOOT    = 2;
	localparam logic [2:0]  GP_WIPE_CLR = 3'h7;
	localparam int unsigned CALIB_W    = 8;

	typedef enum logic [3:0] {
		CMD_SET_GPNVM = 4'h1,
		CMD_CLR_GPNVM = 4'h2,
		CMD_SET_SEC   = 4'h3
	} cmd_t;

	typedef enum logic [2:0] {
		FFP_READ,
		FFP_PAGE_PROG,
		FFP_PAGE_ERASE,
		FFP_FULL_ERASE,
		FFP_LOCK,
		FFP_UNLOCK,
		FFP_PROTECT
	} ffp_cmd_t;

	typedef struct packed {
		logic           security;
		logic [GP_N-1:0] gpnvm;
	} nvm_word_t;

	typedef struct packed {
		logic     valid;
		ffp_cmd_t cmd;
	} ffp_req_t;

endpackage

// ---- verilog/wipe_qualifier.sv ----
`timescale 1ns/1ps
module wipe_qualifier #(
	parameter int unsigned WIPE_CYCLES = nvm_cfg_pkg::WIPE_CYCLES_DEF
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic wipe_pin,
	output logic      wipe_held,
	output logic      wipe_event
);
	localparam int unsigned CW = nvm_cfg_pkg::WIPE_CNT_W;
	localparam logic [CW-1:0] LIMIT = CW'(WIPE_CYCLES);
	localparam logic [CW-1:0] ONE   = CW'(1);

	logic          meta_q, sync_q;
	logic [CW-1:0] cnt_q, cnt_d;
	logic          held_q, held_d;
	logic          ev_q, ev_d;

	// ------------------------------------------------------------
	// Pulse qualification
	// ------------------------------------------------------------
	// Glitches shorter than the minimum restart the count
	always_comb begin
		cnt_d  = cnt_q;
		held_d = held_q;
		ev_d   = 1'b0;
		if (!sync_q) begin
			cnt_d  = '0;
			held_d = 1'b0;
		end else if (cnt_q < LIMIT) begin
			cnt_d = cnt_q + ONE;
		end else if (!held_q) begin
			held_d = 1'b1;
			ev_d   = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			cnt_q  <= '0;
			held_q <= 1'b0;
			ev_q   <= 1'b0;
		end else begin
			meta_q <= wipe_pin;
			sync_q <= meta_q;
			cnt_q  <= cnt_d;
			held_q <= held_d;
			ev_q   <= ev_d;
		end
	end

	assign wipe_held  = held_q;
	assign wipe_event = ev_q;

endmodule

// ---- verilog/nvm_security_boot_config.sv ----
// How it works
// RULE_01 - While secure, refuse debug and fast programming flash accesses.
// RULE_02 - Only the set-security command sets security; no command clears it.
// RULE_03 - Security clears only after wipe pin high then full erase.
// RULE_04 - With security clear, all interfaces reach the flash again.
// RULE_05 - The programmer holds the wipe pin longer than 220 ms.
// RULE_06 - General bits are restored from storage after power loss.
// RULE_07 - Set and clear general bit commands change each general bit.
// RULE_08 - General bit 0 drives the brownout detector enable.
// RULE_09 - Wipe clears general bit 0, disabling the detector.
// RULE_10 - General bit 1 is the brownout reset enable.
// RULE_11 - Wipe clears general bit 1, disabling brownout reset.
// RULE_12 - Eight calibration bits are fixed, never written, untouched by wipe.
// RULE_13 - Fast port takes read, program, erase, lock, unlock, protect.
// RULE_14 - Fast mode only while test pin and both straps are high.
// RULE_15 - General bit 2 picks flash boot; zero boots the ROM at 0x0.
// RULE_16 - Detector disabled by bit 0 goes to its low-current off state.
// RULE_17 - Wipe clears general bit 2, restoring ROM boot.
// RULE_18 - Wipe pin is synchronised and qualified by its minimum time.
`timescale 1ns/1ps
module nvm_security_boot_config #(
	parameter int unsigned WIPE_CYCLES = nvm_cfg_pkg::WIPE_CYCLES_DEF
) (
	input  wire logic                            clk,
	input  wire logic                            reset,
	input  wire logic [nvm_cfg_pkg::ADDR_W-1:0]  addr,
	input  wire logic [nvm_cfg_pkg::DATA_W-1:0]  wdata,
	input  wire logic                            wr,
	input  wire logic                            rd,
	output logic      [nvm_cfg_pkg::DATA_W-1:0]  rdata,
	input  wire nvm_cfg_pkg::nvm_word_t          nvm_in,
	output nvm_cfg_pkg::nvm_word_t               nvm_out,
	output logic                                 nvm_store,
	input  wire logic [nvm_cfg_pkg::CALIB_W-1:0] calib_fuse,
	output logic      [nvm_cfg_pkg::CALIB_W-1:0] calib,
	input  wire logic                            wipe_pin,
	input  wire logic                            full_erase_done,
	input  wire logic                            test_mode_pin,
	input  wire logic                            strap_pin_a,
	input  wire logic                            strap_pin_b,
	output logic                                 fast_programming_mode,
	input  wire nvm_cfg_pkg::ffp_req_t           ffp_req,
	output logic                                 ffp_accept,
	output logic                                 ffp_refuse,
	output nvm_cfg_pkg::ffp_req_t                flash_cmd,
	input  wire logic                            dbg_req,
	output logic                                 dbg_grant,
	output logic                                 security_bit,
	output logic                                 bod_enable,
	output logic                                 bod_off_lowpower,
	output logic                                 bod_reset_enable,
	output logic                                 boot_from_flash,
	output logic                                 rom_at_zero
);

	typedef enum logic [1:0] {SEC_OPEN, SEC_LOCKED, SEC_ARMED} sec_st_t;

	localparam int unsigned GN = nvm_cfg_pkg::GP_N;
	localparam logic [1:0] GP_LAST = 2'(GN - 1);

	function automatic logic idx_ok(input logic [1:0] idx);
		return idx <= GP_LAST;
	endfunction

	function automatic logic [GN-1:0] onehot(input logic [1:0] idx);
		return GN'(1) << idx;
	endfunction

	// ------------------------------------------------------------
	// Wipe pin qualification
	// ------------------------------------------------------------
	logic wipe_held, wipe_event;

	wipe_qualifier #(.WIPE_CYCLES(WIPE_CYCLES)) u_wipe (
		.clk        (clk),
		.reset      (reset),
		.wipe_pin   (wipe_pin),
		.wipe_held  (wipe_held),
		.wipe_event (wipe_event)
	); // RULE_18

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	logic       cmd_go;
	logic [3:0] cmd_code;
	logic [1:0] cmd_idx;
	logic       set_sec, set_gp, clr_gp;

	assign cmd_go   = wr && (addr == nvm_cfg_pkg::ADDR_CMD);
	assign cmd_code = wdata[nvm_cfg_pkg::CMD_MSB:nvm_cfg_pkg::CMD_LSB];
	assign cmd_idx  = wdata[nvm_cfg_pkg::IDX_MSB:nvm_cfg_pkg::IDX_LSB];
	assign set_sec  = cmd_go && (cmd_code == nvm_cfg_pkg::CMD_SET_SEC);
	assign set_gp   = cmd_go && (cmd_code == nvm_cfg_pkg::CMD_SET_GPNVM)
		&& idx_ok(cmd_idx);
	assign clr_gp   = cmd_go && (cmd_code == nvm_cfg_pkg::CMD_CLR_GPNVM)
		&& idx_ok(cmd_idx);

	// ------------------------------------------------------------
	// Security state and general bits
	// ------------------------------------------------------------
	sec_st_t         st_q, st_d;
	logic [GN-1:0]   gp_q, gp_d;
	logic [nvm_cfg_pkg::CALIB_W-1:0] calib_q;
	logic            store_q, store_d;
	logic            secure;

	assign secure = (st_q != SEC_OPEN);

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			SEC_OPEN: begin
				if (set_sec)
					st_d = SEC_LOCKED; // RULE_02
			end
			SEC_LOCKED: begin
				if (wipe_event)
					st_d = SEC_ARMED; // RULE_03
			end
			SEC_ARMED: begin
				// A set in the same cycle as the erase end wins
				if (full_erase_done && !set_sec)
					st_d = SEC_OPEN; // RULE_03
			end
		endcase
	end

	always_comb begin
		gp_d = gp_q;
		if (wipe_event)
			gp_d = gp_q & ~nvm_cfg_pkg::GP_WIPE_CLR; // RULE_09 RULE_11 RULE_17
		if (clr_gp)
			gp_d = gp_d & ~onehot(cmd_idx); // RULE_07
		if (set_gp)
			gp_d = gp_d | onehot(cmd_idx); // RULE_07
		store_d = (gp_d != gp_q) || ((st_d == SEC_OPEN) != !secure);
	end

	// Storage is read back on reset so settings survive power cycles
	always_ff @(posedge clk) begin
		if (reset) begin
			st_q    <= nvm_in.security ? SEC_LOCKED : SEC_OPEN; // RULE_06
			gp_q    <= nvm_in.gpnvm; // RULE_06
			calib_q <= calib_fuse; // RULE_12
			store_q <= 1'b0;
		end else begin
			st_q    <= st_d;
			gp_q    <= gp_d;
			calib_q <= calib_q; // RULE_12
			store_q <= store_d;
		end
	end

	assign nvm_out.security = secure;
	assign nvm_out.gpnvm    = gp_q;
	assign nvm_store        = store_q;
	assign calib            = calib_q;
	assign security_bit     = secure;

	assign bod_enable       = gp_q[nvm_cfg_pkg::GP_BOD_EN]; // RULE_08
	assign bod_off_lowpower = !gp_q[nvm_cfg_pkg::GP_BOD_EN]; // RULE_16
	assign bod_reset_enable = gp_q[nvm_cfg_pkg::GP_BOD_RST]; // RULE_10
	assign boot_from_flash  = gp_q[nvm_cfg_pkg::GP_BOOT]; // RULE_15
	assign rom_at_zero      = !gp_q[nvm_cfg_pkg::GP_BOOT]; // RULE_15

	// ------------------------------------------------------------
	// Access gating
	// ------------------------------------------------------------
	logic                  mode_q, mode_d;
	logic                  acc_q, acc_d, ref_q, ref_d;
	nvm_cfg_pkg::ffp_req_t fcmd_q, fcmd_d;

	always_comb begin
		mode_d = test_mode_pin && strap_pin_a && strap_pin_b; // RULE_14
		acc_d  = 1'b0;
		ref_d  = 1'b0;
		fcmd_d = '0;
		// Requests are ignored outside fast programming mode
		if (mode_q && ffp_req.valid) begin
			if (secure) begin
				ref_d = 1'b1; // RULE_01
			end else begin
				acc_d  = 1'b1; // RULE_04 RULE_13
				fcmd_d = ffp_req; // RULE_13
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mode_q <= 1'b0;
			acc_q  <= 1'b0;
			ref_q  <= 1'b0;
			fcmd_q <= '0;
		end else begin
			mode_q <= mode_d;
			acc_q  <= acc_d;
			ref_q  <= ref_d;
			fcmd_q <= fcmd_d;
		end
	end

	assign fast_programming_mode = mode_q;
	assign ffp_accept            = acc_q;
	assign ffp_refuse            = ref_q;
	assign flash_cmd             = fcmd_q;
	assign dbg_grant             = dbg_req && !secure; // RULE_01 RULE_04

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	logic [nvm_cfg_pkg::DATA_W-1:0] rdata_q, rdata_d;

	always_comb begin
		rdata_d = '0;
		if (rd) begin
			unique case (addr)
				nvm_cfg_pkg::ADDR_STAT: begin
					rdata_d[nvm_cfg_pkg::ST_GP_MSB:nvm_cfg_pkg::ST_GP_LSB]
						= gp_q;
					rdata_d[nvm_cfg_pkg::ST_SEC]   = secure;
					rdata_d[nvm_cfg_pkg::ST_ARMED] = (st_q == SEC_ARMED);
					rdata_d[nvm_cfg_pkg::ST_FFP]   = mode_q;
					rdata_d[nvm_cfg_pkg::ST_WIPE]  = wipe_held;
				end
				nvm_cfg_pkg::ADDR_CALIB: begin
					rdata_d[nvm_cfg_pkg::CALIB_W-1:0] = calib_q;
				end
				default: begin
					rdata_d = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			rdata_q <= '0;
		else
			rdata_q <= rdata_d;
	end

	assign rdata = rdata_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	AST_DBG_REFUSED: assert property ( // RULE_01
		dbg_req && secure |-> !dbg_grant)
		else $error("debug access granted while secure");

	AST_FFP_REFUSED: assert property ( // RULE_01
		mode_q && ffp_req.valid && secure |=> ffp_refuse && !ffp_accept
			&& !flash_cmd.valid)
		else $error("fast port access passed while secure");

	AST_SEC_SET_CAUSE: assert property ( // RULE_02
		!secure ##1 secure |-> $past(set_sec))
		else $error("security set without its command");

	AST_SEC_CLR_CAUSE: assert property ( // RULE_03
		secure ##1 !secure |-> $past(full_erase_done)
			&& $past(st_q) == SEC_ARMED)
		else $error("security cleared without wipe and erase");

	AST_OPEN_ACCESS: assert property ( // RULE_04
		mode_q && ffp_req.valid && !secure |=> ffp_accept
			&& flash_cmd == $past(ffp_req))
		else $error("open device refused fast port access");

	AST_GP_CMD: assert property ( // RULE_07
		set_gp |=> gp_q[$past(cmd_idx)] ##1 1'b1)
		else $error("set general bit did not take");

	AST_WIPE_CLEARS: assert property ( // RULE_09
		wipe_event && !set_gp |=> !bod_enable && !bod_reset_enable
			&& rom_at_zero && bod_off_lowpower)
		else $error("wipe left a general bit set");

	AST_CALIB_FIXED: assert property ( // RULE_12
		!$past(reset) |-> $stable(calib))
		else $error("calibration bits changed");

	AST_FFP_MODE: assert property ( // RULE_14
		!(test_mode_pin && strap_pin_a && strap_pin_b) |=> !mode_q)
		else $error("fast mode entered without all pins high");

	AST_RESTORE: assert property ( // RULE_06
		$past(reset) |-> nvm_out == $past(nvm_in))
		else $error("stored settings not restored");

	COV_LOCK: cover property (!secure ##1 secure);
	COV_UNLOCK: cover property (st_q == SEC_ARMED ##1 !secure);
	COV_FFP_REF: cover property (ffp_refuse);
	COV_BOOT_FLASH: cover property (!boot_from_flash ##1 boot_from_flash);

endmodule

// ---- tb/nvm_far_side.sv ----
`timescale 1ns/1ps
module nvm_far_side #(
	parameter int unsigned HOLD      = 20,
	parameter int unsigned ERASE_LAT = 3
) (
	input  wire logic                   clk,
	input  wire logic                   wipe_go,
	input  wire logic                   erase_go,
	input  wire nvm_cfg_pkg::nvm_word_t nvm_out,
	input  wire logic                   nvm_store,
	output nvm_cfg_pkg::nvm_word_t      nvm_in,
	output logic                        wipe_pin,
	output logic                        full_erase_done
);
	int unsigned wipe_cnt  = 0;
	int unsigned erase_cnt = 0;

	initial begin
		nvm_in = '0;
		wipe_pin = 1'b0;
		full_erase_done = 1'b0;
	end

	// Cells keep their contents while the core is held in reset
	always @(posedge clk) begin
		if (nvm_store) begin
			nvm_in <= nvm_out;
		end
		if (wipe_go) begin
			wipe_cnt <= HOLD;
		end else if (wipe_cnt != 0) begin
			wipe_cnt <= wipe_cnt - 1;
		end
		wipe_pin <= wipe_go || wipe_cnt > 1;
		if (erase_go) begin
			erase_cnt <= ERASE_LAT;
		end else if (erase_cnt != 0) begin
			erase_cnt <= erase_cnt - 1;
		end
		full_erase_done <= erase_cnt == 1;
	end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	logic                  clk = 1'b0;
	logic                  reset = 1'b1;
	logic [7:0]            addr = 8'h00;
	logic [31:0]           wdata = 32'h0000_0000;
	logic                  wr = 1'b0;
	logic                  rd = 1'b0;
	logic [7:0]            calib_fuse = 8'ha5;
	logic                  test_mode_pin = 1'b0;
	logic                  strap_pin_a = 1'b0;
	logic                  strap_pin_b = 1'b0;
	nvm_cfg_pkg::ffp_req_t ffp_req = '0;
	logic                  dbg_req = 1'b0;
	logic                  wipe_go = 1'b0;
	logic                  erase_go = 1'b0;
	wire logic [31:0]      rdata;
	nvm_cfg_pkg::nvm_word_t nvm_in;
	nvm_cfg_pkg::nvm_word_t nvm_out;
	wire logic             nvm_store;
	wire logic [7:0]       calib;
	wire logic             wipe_pin;
	wire logic             full_erase_done;
	wire logic             fast_programming_mode;
	wire logic             ffp_accept;
	wire logic             ffp_refuse;
	nvm_cfg_pkg::ffp_req_t flash_cmd;
	wire logic             dbg_grant;
	wire logic             security_bit;
	wire logic             bod_enable;
	wire logic             bod_off_lowpower;
	wire logic             bod_reset_enable;
	wire logic             boot_from_flash;
	wire logic             rom_at_zero;
	int                    err_total = 0;
	int                    n_tests = 0;
	int                    cycles = 0;

	// Short wipe count keeps the run brief
	nvm_security_boot_config #(.WIPE_CYCLES(10)) u_nvm_security_boot_config (
		.clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .nvm_in, .nvm_out,
		.nvm_store, .calib_fuse, .calib, .wipe_pin, .full_erase_done,
		.test_mode_pin, .strap_pin_a, .strap_pin_b, .fast_programming_mode,
		.ffp_req, .ffp_accept, .ffp_refuse, .flash_cmd, .dbg_req, .dbg_grant,
		.security_bit, .bod_enable, .bod_off_lowpower, .bod_reset_enable,
		.boot_from_flash, .rom_at_zero
	);

	nvm_far_side u_nvm_far_side (
		.clk, .wipe_go, .erase_go, .nvm_out, .nvm_store, .nvm_in, .wipe_pin,
		.full_erase_done
	);

	always #50 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			summarize();
		end
	end

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(negedge clk);
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp,
			input string what);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(what, exp, rdata);
	endtask

	task automatic cmd(input logic [3:0] code, input logic [1:0] idx);
		wr_reg(nvm_cfg_pkg::ADDR_CMD, {22'h0, idx, 4'h0, code});
	endtask

	// ans: 2'b10 accepted, 2'b01 refused, 2'b00 no answer
	task automatic ffp(input nvm_cfg_pkg::ffp_cmd_t c, input logic [1:0] ans);
		@(posedge clk);
		ffp_req <= '{valid: 1'b1, cmd: c};
		@(posedge clk);
		ffp_req <= '0;
		@(negedge clk);
		chk("ffp answer", 32'(ans), 32'({ffp_accept, ffp_refuse}));
		chk("flash cmd", ans[1] ? 32'({1'b1, c}) : 32'h0, 32'(flash_cmd));
	endtask

	task automatic gen(input logic [2:0] g);
		chk("gen bits", {27'h0, ~g[0], ~g[2], g},
			{27'h0, bod_off_lowpower, rom_at_zero, boot_from_flash,
			bod_reset_enable, bod_enable});
	endtask

	task automatic kick(input bit w);
		@(posedge clk);
		if (w) begin
			wipe_go <= 1'b1;
		end else begin
			erase_go <= 1'b1;
		end
		@(posedge clk);
		wipe_go <= 1'b0;
		erase_go <= 1'b0;
		repeat (30) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic pins(input logic [2:0] p);
		@(posedge clk);
		{test_mode_pin, strap_pin_a, strap_pin_b} <= p;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("fast mode", 32'(p == 3'h7), 32'(fast_programming_mode));
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		chk("calib out", 32'h0000_00a5, 32'(calib));
		rd_reg(nvm_cfg_pkg::ADDR_CALIB, 32'h0000_00a5, "calib reg");
		rd_reg(8'h0c, 32'h0000_0000, "unmapped");
		gen(3'h0);
		for (int i = 0; i < 3; i++) begin
			cmd(nvm_cfg_pkg::CMD_SET_GPNVM, 2'(i));
		end
		gen(3'h7);
		cmd(nvm_cfg_pkg::CMD_CLR_GPNVM, 2'h0);
		gen(3'h6);
		rd_reg(nvm_cfg_pkg::ADDR_STAT, 32'h0000_0006, "status");
		// Power cycle: the far side hands back what was written out
		@(posedge clk);
		reset <= 1'b1;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		gen(3'h6);
		for (int m = 0; m < 3; m++) begin
			pins(~(3'h1 << m));
			ffp(nvm_cfg_pkg::FFP_READ, 2'b00);
		end
		pins(3'h7);
		for (int i = 0; i < 7; i++) begin
			ffp(nvm_cfg_pkg::ffp_cmd_t'(i), 2'b10);
		end
		@(posedge clk);
		dbg_req <= 1'b1;
		cmd(nvm_cfg_pkg::CMD_SET_SEC, 2'h0);
		chk("security", 32'h1, 32'(security_bit));
		chk("store", 32'h1, 32'(nvm_store));
		chk("nvm out", 32'h0000_000e, 32'(nvm_out));
		chk("debug grant", 32'h0, 32'(dbg_grant));
		ffp(nvm_cfg_pkg::FFP_PAGE_PROG, 2'b01);
		cmd(4'hf, 2'h0);
		chk("store idle", 32'h0, 32'(nvm_store));
		cmd(nvm_cfg_pkg::CMD_CLR_GPNVM, 2'h3);
		chk("store idle", 32'h0, 32'(nvm_store));
		gen(3'h6);
		kick(1'b0);
		chk("security kept", 32'h1, 32'(security_bit));
		pins(3'h0);
		kick(1'b1);
		gen(3'h0);
		chk("calib kept", 32'h0000_00a5, 32'(calib));
		rd_reg(nvm_cfg_pkg::ADDR_STAT, 32'h0000_0030, "armed");
		chk("security held", 32'h1, 32'(security_bit));
		kick(1'b0);
		chk("security clear", 32'h0, 32'(security_bit));
		chk("debug open", 32'h1, 32'(dbg_grant));
		pins(3'h7);
		ffp(nvm_cfg_pkg::FFP_FULL_ERASE, 2'b10);
		rd_reg(nvm_cfg_pkg::ADDR_STAT, 32'h0000_0040, "fast status");
		summarize();
	end
endmodule
